// file: rtl/octal_ctrl_pkg.sv
// Shared constants and types for the octal driver serial control block
package octal_ctrl_pkg;

  localparam int          WORD_BITS     = 16;
  localparam int          CH_COUNT      = 8;
  localparam int          CNT_BITS      = 4;
  localparam int          SYNC_STAGES   = 2;

  // Field positions inside a received word
  localparam int          KEY_MSB       = 15;
  localparam int          KEY_LSB       = 12;
  localparam int          MODE_MSB      = 11;
  localparam int          MODE_LSB      = 8;
  localparam int          DATA_MSB      = 7;
  localparam int          DATA_LSB      = 0;

  // Key-word and writing mode codes
  localparam logic [3:0]  KEY_VALID     = 4'ha;
  localparam logic [3:0]  MODE_OUTPUT   = 4'hc;
  localparam logic [3:0]  MODE_DIAG     = 4'h3;
  localparam logic [3:0]  MODE_PROTECT  = 4'ha;

  // Fault codes per channel, two bits each
  localparam logic [1:0]  FLT_NONE      = 2'h0;
  localparam logic [1:0]  FLT_OPEN      = 2'h1;
  localparam logic [1:0]  FLT_SHORT     = 2'h2;
  localparam logic [1:0]  FLT_OVERCUR   = 2'h3;

  // Values after reset, and the all-ones thermal fault word
  localparam logic [7:0]  CMD_RESET     = 8'h00;
  localparam logic [15:0] FAULT_RESET   = 16'h0000;
  localparam logic [15:0] FAULT_THERMAL = 16'hffff;
  localparam logic [3:0]  CNT_RESET     = 4'h0;
  // Pin synchronisers start at the pull levels: select, clock, data, reset high
  localparam logic [6:0]  PIN_PRESET    = 7'h0f;

  // Channels 6 to 8 take a parallel enable, placed at bits 5 to 7
  localparam int          PAR_LSB       = 5;

  typedef struct packed {
    logic [3:0] key;
    logic [3:0] mode;
    logic [7:0] data;
  } cmd_word_t;

  typedef struct packed {
    logic [7:0] drive_on;
    logic [7:0] diag_latch;
    logic [7:0] linear_limit;
  } chan_cfg_t;

  typedef enum logic [0:0] {
    LINK_IDLE  = 1'b0,
    LINK_SHIFT = 1'b1
  } link_state_t;

endpackage

// file: rtl/octal_driver_spi_control.sv
// Serial command and fault report front end of the eight channel load driver
// Functional notes
// - Serial output undriven while chip select high; driven from its falling edge.
// - First 16 bits out after chip select falls are the fault register.
// - After fault bits, serial output repeats serial input delayed 16 clocks.
// - Input sampled on rising serial clock; output changes on falling edge.
// - Words travel least significant bit first, both directions.
// - Bits 15..12 are the key-word; pattern 1010 required for acceptance.
// - Bits 11..8 pick writing mode: outputs, diagnosis latch, or protection.
// - Output mode 1100: low byte turns outputs 8..1 on or off.
// - Diagnosis mode 0011: one selects latch, zero selects no-latch per channel.
// - Protection mode 1010: one selects linear limit, zero selects switch-off.
// - Fault register cleared at chip select rise only on whole words and valid key.
// - A partial word at chip select rise is discarded; commands unchanged.
// - Power-on reset clears commands and faults: outputs off, no-latch, switch-off.
// - Parallel enables for channels 6..8 are OR'd with their command bits.
// - Reset pin low clears all registers except the pin synchronisers and buffer storage, and switches every output off.
// - Fault register holds two bits per channel, channel 1 lowest.
// - Thermal shutdown at chip select fall reports all fault bits as one.
`timescale 1ns/1ns
`default_nettype none

module octal_driver_spi_control #(
  parameter int BUF_DEPTH = 2,
  parameter int BUF_WIDTH = octal_ctrl_pkg::WORD_BITS
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       chip_sel_n_pin,
  input  wire logic       serial_clk_pin,
  input  wire logic       serial_in_pin,
  input  wire logic       reset_n_pin,
  input  wire logic       par_enable_ch6,
  input  wire logic       par_enable_ch7,
  input  wire logic       par_enable_ch8,
  input  wire logic [7:0] fault_event,
  input  wire logic [15:0] fault_code,
  input  wire logic [7:0] thermal_shutdown,
  output logic            serial_out,
  output logic            serial_out_oe_n,
  output logic [7:0]      drive_on,
  output logic [7:0]      diag_latch,
  output logic [7:0]      linear_limit,
  output logic            cmd_ready
);

  localparam int PTR_BITS = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

  // Two-flop synchronisers for every pin, one bit per pin in each row
  localparam int NPIN = 7;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1_reg;
  logic [NPIN-1:0] sync2_reg;
  logic [NPIN-1:0] sync3_reg;

  assign pin_raw = {par_enable_ch8, par_enable_ch7, par_enable_ch6, reset_n_pin,
                    serial_in_pin, serial_clk_pin, chip_sel_n_pin};

  // Preset to the pins' pull levels so that no false edge follows reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync1_reg <= octal_ctrl_pkg::PIN_PRESET;
    end else begin
      sync1_reg <= pin_raw;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync2_reg <= octal_ctrl_pkg::PIN_PRESET;
    end else begin
      sync2_reg <= sync1_reg;
    end
  end

  // Third row only remembers the settled level for edge finding
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync3_reg <= octal_ctrl_pkg::PIN_PRESET;
    end else begin
      sync3_reg <= sync2_reg;
    end
  end

  wire       cs_n_s     = sync2_reg[0];
  wire       sclk_s     = sync2_reg[1];
  wire       sdi_s      = sync2_reg[2];
  wire       pin_rst_n  = sync2_reg[3];
  wire [2:0] par_en_s   = sync2_reg[6:4];
  wire       cs_fall    = sync3_reg[0] & ~cs_n_s;
  wire       cs_rise    = ~sync3_reg[0] & cs_n_s;
  wire       sclk_rise  = ~sync3_reg[1] & sclk_s;
  wire       sclk_fall  = sync3_reg[1] & ~sclk_s;
  // Pin reset acts like a synchronous clear on top of rst
  wire       clr        = rst | ~pin_rst_n;

  // Link state
  octal_ctrl_pkg::link_state_t state_reg;
  octal_ctrl_pkg::link_state_t state_next;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      octal_ctrl_pkg::LINK_IDLE:  if (cs_fall) state_next = octal_ctrl_pkg::LINK_SHIFT;
      octal_ctrl_pkg::LINK_SHIFT: if (cs_rise) state_next = octal_ctrl_pkg::LINK_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (clr) state_reg <= octal_ctrl_pkg::LINK_IDLE;
    else     state_reg <= state_next;
  end

  wire shifting = (state_reg == octal_ctrl_pkg::LINK_SHIFT);

  // Receive side: LSB first, so bits enter at the top and move down
  logic [15:0] rx_shift_reg;
  logic [3:0]  bit_cnt_reg;
  logic        word_seen_reg;
  logic        pend_bit_reg;

  wire         take_bit    = shifting & sclk_rise;
  wire         frame_start = clr | cs_fall;
  wire [3:0]   bit_cnt_inc = bit_cnt_reg + 4'h1;
  // Counter wraps at a word boundary; the flag keeps a zero count from meaning no bits
  wire         word_done   = take_bit & (bit_cnt_inc == octal_ctrl_pkg::CNT_RESET);

  always_ff @(posedge sys_clk) begin
    if (frame_start) begin
      rx_shift_reg <= octal_ctrl_pkg::FAULT_RESET;
    end else if (take_bit) begin
      rx_shift_reg <= {sdi_s, rx_shift_reg[15:1]};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (frame_start) begin
      bit_cnt_reg <= octal_ctrl_pkg::CNT_RESET;
    end else if (take_bit) begin
      bit_cnt_reg <= bit_cnt_inc;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (frame_start) begin
      word_seen_reg <= 1'b0;
    end else if (word_done) begin
      word_seen_reg <= 1'b1;
    end
  end

  // Last sampled input bit, waiting to enter the transmit register at the next fall
  always_ff @(posedge sys_clk) begin
    if (frame_start) begin
      pend_bit_reg <= 1'b0;
    end else if (take_bit) begin
      pend_bit_reg <= sdi_s;
    end
  end

  // Transmit side: fault word first, then input delayed by one word
  logic [15:0] tx_shift_reg;
  logic        so_reg;
  logic        oe_n_reg;
  logic [15:0] fault_reg;

  wire         hot       = |thermal_shutdown;
  wire [15:0]  tx_load   = hot ? octal_ctrl_pkg::FAULT_THERMAL : fault_reg;

  // Shifting stops at the chip select rise so the wrapped bits stay put
  wire         tx_step   = shifting & sclk_fall & ~cs_rise;

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      tx_shift_reg <= octal_ctrl_pkg::FAULT_RESET;
    end else if (cs_fall) begin
      tx_shift_reg <= tx_load;
    end else if (tx_step) begin
      // Captured input bit enters at the top and reaches bit 0 fifteen falls later
      tx_shift_reg <= {pend_bit_reg, tx_shift_reg[15:1]};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      so_reg <= 1'b0;
    end else if (cs_fall) begin
      so_reg <= tx_load[0];
    end else if (tx_step) begin
      so_reg <= tx_shift_reg[1];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      oe_n_reg <= 1'b1;
    end else if (cs_fall) begin
      oe_n_reg <= 1'b0;
    end else if (cs_rise) begin
      oe_n_reg <= 1'b1;
    end
  end

  assign serial_out      = so_reg;
  assign serial_out_oe_n = oe_n_reg;

  // Word check at chip select rise
  octal_ctrl_pkg::cmd_word_t rx_word;
  assign rx_word = rx_shift_reg;

  wire whole_words = word_seen_reg & (bit_cnt_reg == octal_ctrl_pkg::CNT_RESET);
  wire key_ok      = (rx_word.key == octal_ctrl_pkg::KEY_VALID);
  wire word_valid  = shifting & cs_rise & whole_words & key_ok;

  // Fault register: detector updates win over a clear in the same cycle
  logic [15:0] fault_next;

  always_comb begin
    fault_next = word_valid ? octal_ctrl_pkg::FAULT_RESET : fault_reg;
    for (int ch = 0; ch < octal_ctrl_pkg::CH_COUNT; ch++) begin
      if (fault_event[ch])
        fault_next[2*ch +: 2] = fault_code[2*ch +: 2];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clr) fault_reg <= octal_ctrl_pkg::FAULT_RESET;
    else     fault_reg <= fault_next;
  end

  // Two-entry word buffer between the link and the command registers
  logic [BUF_WIDTH-1:0] buf_mem_reg [BUF_DEPTH];
  logic [PTR_BITS-1:0]  wr_ptr_reg;
  logic [PTR_BITS-1:0]  rd_ptr_reg;
  logic [PTR_BITS:0]    fill_reg;

  wire buf_full   = (fill_reg == (PTR_BITS+1)'(BUF_DEPTH));
  wire buf_empty  = (fill_reg == '0);
  wire push       = word_valid & ~buf_full;
  wire pop_valid  = ~buf_empty;
  // Drain stalls while the pin reset holds the channel registers cleared
  wire pop_ready  = pin_rst_n;
  wire pop        = pop_valid & pop_ready;

  assign cmd_ready = ~buf_full;

  function automatic logic [PTR_BITS-1:0] ptr_inc(input logic [PTR_BITS-1:0] p);
    ptr_inc = (p == PTR_BITS'(BUF_DEPTH - 1)) ? '0 : p + PTR_BITS'(1);
  endfunction

  // Storage needs no reset: the fill count alone says which entries hold words
  always_ff @(posedge sys_clk) begin
    if (push) begin
      buf_mem_reg[wr_ptr_reg] <= rx_shift_reg;
    end
  end

  // Pointers follow the pin reset too, so no stale word survives it
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      wr_ptr_reg <= '0;
    end else if (push) begin
      wr_ptr_reg <= ptr_inc(wr_ptr_reg);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      rd_ptr_reg <= '0;
    end else if (pop) begin
      rd_ptr_reg <= ptr_inc(rd_ptr_reg);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      fill_reg <= '0;
    end else if (push && !pop) begin
      fill_reg <= fill_reg + (PTR_BITS+1)'(1);
    end else if (pop && !push) begin
      fill_reg <= fill_reg - (PTR_BITS+1)'(1);
    end
  end

  // Command registers, updated from the buffer head
  octal_ctrl_pkg::cmd_word_t head;
  assign head = buf_mem_reg[rd_ptr_reg];

  function automatic logic mode_is(input logic [3:0] mode, input logic [3:0] code);
    mode_is = (mode == code);
  endfunction

  wire sel_out  = pop & mode_is(head.mode, octal_ctrl_pkg::MODE_OUTPUT);
  wire sel_diag = pop & mode_is(head.mode, octal_ctrl_pkg::MODE_DIAG);
  wire sel_prot = pop & mode_is(head.mode, octal_ctrl_pkg::MODE_PROTECT);

  logic [7:0] out_cmd_reg;
  logic [7:0] diag_reg;
  logic [7:0] prot_reg;

  // Unknown mode codes fall through every select and leave all three alone
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      out_cmd_reg <= octal_ctrl_pkg::CMD_RESET;
    end else if (sel_out) begin
      out_cmd_reg <= head.data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      diag_reg <= octal_ctrl_pkg::CMD_RESET;
    end else if (sel_diag) begin
      diag_reg <= head.data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      prot_reg <= octal_ctrl_pkg::CMD_RESET;
    end else if (sel_prot) begin
      prot_reg <= head.data;
    end
  end

  // Channel stage drive, registered
  wire [7:0] par_mask = {par_en_s, 5'h00};
  octal_ctrl_pkg::chan_cfg_t cfg_reg;

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      cfg_reg <= '0;
    end else begin
      cfg_reg.drive_on     <= out_cmd_reg | par_mask;
      cfg_reg.diag_latch   <= diag_reg;
      cfg_reg.linear_limit <= prot_reg;
    end
  end

  assign drive_on     = cfg_reg.drive_on;
  assign diag_latch   = cfg_reg.diag_latch;
  assign linear_limit = cfg_reg.linear_limit;

endmodule

`default_nettype wire

// file: sim/octal_ctrl_asserts.sv
// Port-level checker for the octal driver serial control block
`timescale 1ns/1ns
`default_nettype none
module octal_ctrl_asserts (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        chip_sel_n_pin,
  input wire logic        reset_n_pin,
  input wire logic        par_enable_ch7,
  input wire logic [7:0]  thermal_shutdown,
  input wire logic        serial_out,
  input wire logic        serial_out_oe_n,
  input wire logic [7:0]  drive_on,
  input wire logic [7:0]  diag_latch,
  input wire logic [7:0]  linear_limit,
  input wire logic        cmd_ready
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_oe_idle; chip_sel_n_pin [*6] |-> serial_out_oe_n; endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("output driven while deselected");
  property p_oe_drive; !chip_sel_n_pin [*6] |-> !serial_out_oe_n; endproperty
  a_oe_drive: assert property (p_oe_drive)
    else $error("output not driven while selected");
  property p_oe_release; $rose(chip_sel_n_pin) |-> ##[1:6] serial_out_oe_n; endproperty
  a_oe_release: assert property (p_oe_release)
    else $error("output not released after deselect");
  property p_par; (par_enable_ch7 && reset_n_pin) [*5] |-> drive_on[6]; endproperty
  a_par: assert property (p_par)
    else $error("parallel enable not applied");
  property p_pin_rst;
    !reset_n_pin [*6] |-> drive_on == 8'h00 && diag_latch == 8'h00 && linear_limit == 8'h00;
  endproperty
  a_pin_rst: assert property (p_pin_rst)
    else $error("reset pin did not clear outputs");
  // Diagnosis and protection commands may only move while deselected
  property p_cmd_hold; !chip_sel_n_pin [*8] |-> $stable(diag_latch) && $stable(linear_limit);
  endproperty
  a_cmd_hold: assert property (p_cmd_hold)
    else $error("command changed inside a frame");
  property p_thermal; $fell(serial_out_oe_n) && (|thermal_shutdown) |=> serial_out; endproperty
  a_thermal: assert property (p_thermal)
    else $error("thermal word not all ones");
  property p_rst;
    disable iff (1'b0) rst |=> drive_on == 8'h00 && serial_out_oe_n && cmd_ready;
  endproperty
  a_rst: assert property (p_rst)
    else $error("reset values wrong");
  c_frame: cover property ($rose(chip_sel_n_pin));
  c_thermal: cover property ($fell(serial_out_oe_n) && (|thermal_shutdown));
  c_par: cover property (drive_on[7:5] == 3'h7);
endmodule
bind octal_driver_spi_control octal_ctrl_asserts u_chk (
  .sys_clk(sys_clk), .rst(rst), .chip_sel_n_pin(chip_sel_n_pin), .reset_n_pin(reset_n_pin),
  .par_enable_ch7(par_enable_ch7), .thermal_shutdown(thermal_shutdown),
  .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n), .drive_on(drive_on),
  .diag_latch(diag_latch), .linear_limit(linear_limit), .cmd_ready(cmd_ready));
`default_nettype wire

// file: sim/spi_host_model.sv
// Host serial master model driving the link pins
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
  input  wire logic sys_clk,
  input  wire logic serial_out,
  input  wire logic serial_out_oe_n,
  output var logic  chip_sel_n_pin,
  output var logic  serial_clk_pin,
  output var logic  serial_in_pin
);
  // Data line idles at its pull-up level; clock stands still between frames
  initial begin
    chip_sel_n_pin = 1'b1;
    serial_clk_pin = 1'b0;
    serial_in_pin  = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Half link period is 4 system cycles; an undriven output reads as unknown
  task automatic frame(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
    rx = 'x;
    chip_sel_n_pin = 1'b0;
    tick(8);
    for (int i = 0; i < nbits; i++) begin
      serial_in_pin = tx[i];
      tick(4);
      serial_clk_pin = 1'b1;
      tick(1);
      rx[i] = (serial_out_oe_n === 1'b0) ? serial_out : 1'bx;
      tick(3);
      serial_clk_pin = 1'b0;
    end
    tick(8);
    chip_sel_n_pin = 1'b1;
    serial_in_pin  = 1'b1;
  endtask
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the octal driver serial control block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        reset_n_pin = 1'b1;
  logic [2:0]  par = 3'h0;
  logic [7:0]  fault_event = 8'h00;
  logic [15:0] fault_code = 16'h0000;
  logic [7:0]  thermal_shutdown = 8'h00;
  logic [31:0] rx;
  wire logic   cs_n, sclk, sdi, serial_out, serial_out_oe_n, cmd_ready;
  wire logic [7:0] drive_on, diag_latch, linear_limit;
  int          fails = 0;
  int          num_checks = 0;
  always #20 sys_clk = ~sys_clk;
  spi_host_model host (.sys_clk(sys_clk), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n), .chip_sel_n_pin(cs_n), .serial_clk_pin(sclk),
    .serial_in_pin(sdi));
  octal_driver_spi_control dut (.sys_clk(sys_clk), .rst(rst), .chip_sel_n_pin(cs_n),
    .serial_clk_pin(sclk), .serial_in_pin(sdi), .reset_n_pin(reset_n_pin),
    .par_enable_ch6(par[0]), .par_enable_ch7(par[1]), .par_enable_ch8(par[2]),
    .fault_event(fault_event), .fault_code(fault_code), .thermal_shutdown(thermal_shutdown),
    .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n), .drive_on(drive_on),
    .diag_latch(diag_latch), .linear_limit(linear_limit), .cmd_ready(cmd_ready));
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h got %h", name, exp, got);
    end
  endtask
  task automatic summarize;
    if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic xfer(input logic [31:0] tx, input int n);
    int k;
    host.frame(tx, n, rx);
    k = 0;
    while (serial_out_oe_n !== 1'b1 && k < 20) begin
      tick(1);
      k++;
    end
    if (k == 20) begin
      fails++;
      summarize();
    end
    tick(8);
  endtask
  task automatic set_faults(input logic [15:0] code);
    fault_code = code;
    fault_event = 8'hff;
    tick(1);
    fault_event = 8'h00;
  endtask
  initial begin
    #2_000_000;
    fails++;
    summarize();
  end
  initial begin
    tick(3);
    rst = 1'b0;
    tick(4);
    chk("cmd_regs", 16'h0000, {diag_latch, linear_limit});
    chk("cmd_ready", 16'h0001, {15'h0000, cmd_ready});
    set_faults(16'h1be4);
    xfer(32'hac5a_1234, 32);
    chk("fault_word", 16'h1be4, rx[15:0]);
    chk("wrap_word", 16'h1234, rx[31:16]);
    chk("drive_on", 16'h005a, {8'h00, drive_on});
    xfer(32'h0000_a33c, 16);
    chk("fault_clear", 16'h0000, rx[15:0]);
    chk("diag_latch", 16'h003c, {8'h00, diag_latch});
    xfer(32'h0000_aac3, 16);
    chk("linear_limit", 16'h3cc3, {diag_latch, linear_limit});
    set_faults(16'h3c0f);
    xfer(32'h0000_acff, 12);
    chk("partial_cmd", 16'h005a, {8'h00, drive_on});
    xfer(32'h0000_5cff, 16);
    chk("partial_fault", 16'h3c0f, rx[15:0]);
    chk("badkey_cmd", 16'h005a, {8'h00, drive_on});
    xfer(32'h0000_af00, 16);
    chk("badkey_fault", 16'h3c0f, rx[15:0]);
    chk("unknown_mode", 16'h3cc3, {diag_latch, linear_limit});
    chk("unknown_drive", 16'h005a, {8'h00, drive_on});
    xfer(32'h0000_ac00, 16);
    chk("mode_clear", 16'h0000, rx[15:0]);
    par = 3'h7;
    tick(8);
    chk("par_or", 16'h00e0, {8'h00, drive_on});
    par = 3'h0;
    thermal_shutdown = 8'h10;
    xfer(32'h0000_ac81, 16);
    chk("thermal_word", 16'hffff, rx[15:0]);
    thermal_shutdown = 8'h00;
    set_faults(16'h0003);
    reset_n_pin = 1'b0;
    tick(8);
    chk("pin_reset", 16'h0000, {drive_on, diag_latch | linear_limit});
    reset_n_pin = 1'b1;
    tick(6);
    xfer(32'h0000_ac00, 16);
    chk("pin_fault", 16'h0000, rx[15:0]);
    summarize();
  end
endmodule
`default_nettype wire
